/* File: src/hall_cond_pkg.sv */
package hall_cond_pkg;
    // Command addresses of the conditioning settings
    localparam logic [2:0] ADDR_GAIN = 3'h0;
    localparam logic [2:0] ADDR_OFFSET = 3'h1;
    localparam logic [2:0] ADDR_LOW_LIMIT = 3'h2;
    localparam logic [2:0] ADDR_HIGH_LIMIT = 3'h3;
    localparam logic [2:0] ADDR_LOCK = 3'h4;
    localparam logic [2:0] ADDR_SAMPLE = 3'h5;
    // Field widths
    localparam int GAIN_W = 14;
    localparam int OFFSET_W = 11;
    localparam int LOW_W = 10;
    localparam int HIGH_W = 11;
    localparam int SAMPLE_W = 14;
    localparam int DATA_W = 14;
    localparam int OUT_W = 11;
    // Fixed point: gain LSB is 2^-11, output LSB is one supply over 2048
    localparam int GAIN_FRAC = 11;
    localparam int OFFSET_SHIFT = 1;
    localparam logic signed [15:0] FULL_SUPPLY = 16'sh0800;
    localparam logic signed [15:0] OUT_MAX = 16'sh07FF;
    // Reset values of the settings
    localparam logic [13:0] GAIN_RST = 14'h0800;
    localparam logic [10:0] OFFSET_RST = 11'h000;
    localparam logic [9:0] LOW_RST = 10'h000;
    localparam logic [10:0] HIGH_RST = 11'h7FF;
endpackage : hall_cond_pkg

/* File: src/hall_output_conditioning_lock.sv */
`timescale 1ns/100ps
`default_nettype none
// Contract
// - Gain is signed multiplier, minus four to four
// - Unity gain: 2048 counts give one supply
// - Offset adds, spans plus/minus supply, 4.9mV steps
// - Negative offset caps output at offset plus supply
// - Lower limit zero to half supply
// - Upper limit zero to full supply
// - Lock ignores all commands; settings freeze, but reset reloads their defaults
// - Lock never cleared by command or reset
// - Raw 14-bit field sample is readable
// - Unlimited rewrites while unlocked
// - Multiply, add offset, then clamp between limits
// - Analog output off during any exchange while unlocked; stays on once locked
module hall_output_conditioning_lock
    import hall_cond_pkg::*;
(
    // Clock and reset
    input wire logic i_clock,
    input wire logic i_rstn,
    // Decoded command port from the supply-modulation receiver
    input wire logic i_comm_active,
    input wire logic i_cmd_valid,
    input wire logic i_cmd_write,
    input wire logic [2:0] i_cmd_addr,
    input wire logic [DATA_W-1:0] i_cmd_wdata,
    input wire logic i_cmd_store,
    output logic o_rvalid,
    output logic [DATA_W-1:0] o_rdata,
    // Nonvolatile lock image and store request
    input wire logic i_lock_stored,
    output logic o_store_req,
    // Filtered field sample
    input wire logic [SAMPLE_W-1:0] i_sample,
    // Output converter
    output logic [OUT_W-1:0] o_out_code,
    output logic o_out_enable,
    output logic o_locked
);

    // ----------------------------------------------------------------
    // Saturation helper
    // ----------------------------------------------------------------
    function automatic logic signed [15:0] sat16(input logic signed [31:0] v);
        logic signed [15:0] r;
        r = 16'sh0000;
        if (v > 32'sd32767) begin
            r = 16'sh7FFF;
        end else if (v < -32'sd32768) begin
            r = 16'sh8000;
        end else begin
            r = v[15:0];
        end
        return r;
    endfunction : sat16

    // ----------------------------------------------------------------
    // Limit helpers
    // ----------------------------------------------------------------
    function automatic logic signed [15:0] min16(input logic signed [15:0] a, b);
        logic signed [15:0] r;
        r = a;
        if (b < a) begin
            r = b;
        end
        return r;
    endfunction : min16

    function automatic logic signed [15:0] max16(input logic signed [15:0] a, b);
        logic signed [15:0] r;
        r = a;
        if (b > a) begin
            r = b;
        end
        return r;
    endfunction : max16

    // Highest reachable code: a negative offset leaves one supply above it
    function automatic logic signed [15:0] reach_top(input logic signed [15:0] v);
        logic signed [15:0] r;
        r = OUT_MAX;
        if (v < 16'sh0000) begin
            r = min16(v + FULL_SUPPLY, OUT_MAX);
        end
        return r;
    endfunction : reach_top

    // ----------------------------------------------------------------
    // Settings and lock
    // ----------------------------------------------------------------
    logic [GAIN_W-1:0] gain_r, gain_nxt;
    logic [OFFSET_W-1:0] offset_r, offset_nxt;
    logic [LOW_W-1:0] low_r, low_nxt;
    logic [HIGH_W-1:0] high_r, high_nxt;
    logic lock_r, lock_nxt;
    logic rvalid_r, rvalid_nxt;
    logic [DATA_W-1:0] rdata_r, rdata_nxt;
    logic store_r, store_nxt;
    logic take;

    // A locked part answers nothing, so every command is dropped here
    assign take = i_cmd_valid && !lock_r;

    always_comb begin
        gain_nxt = gain_r;
        offset_nxt = offset_r;
        low_nxt = low_r;
        high_nxt = high_r;
        rvalid_nxt = 1'b0;
        // Read data holds until the next read or reset
        rdata_nxt = rdata_r;
        store_nxt = 1'b0;
        if (!i_rstn) begin
            gain_nxt = GAIN_RST;
            offset_nxt = OFFSET_RST;
            low_nxt = LOW_RST;
            high_nxt = HIGH_RST;
            rdata_nxt = '0;
        end else if (take && i_cmd_write) begin
            // Any number of rewrites is accepted until locked
            store_nxt = i_cmd_store;
            case (i_cmd_addr)
                ADDR_GAIN: gain_nxt = i_cmd_wdata;
                ADDR_OFFSET: offset_nxt = i_cmd_wdata[OFFSET_W-1:0];
                ADDR_LOW_LIMIT: low_nxt = i_cmd_wdata[LOW_W-1:0];
                ADDR_HIGH_LIMIT: high_nxt = i_cmd_wdata[HIGH_W-1:0];
                ADDR_LOCK: store_nxt = i_cmd_store | i_cmd_wdata[0];
                default: store_nxt = 1'b0;
            endcase
        end else if (take) begin
            rvalid_nxt = 1'b1;
            case (i_cmd_addr)
                ADDR_GAIN: rdata_nxt = gain_r;
                ADDR_OFFSET: rdata_nxt = {{(DATA_W-OFFSET_W){1'b0}}, offset_r};
                ADDR_LOW_LIMIT: rdata_nxt = {{(DATA_W-LOW_W){1'b0}}, low_r};
                ADDR_HIGH_LIMIT: rdata_nxt = {{(DATA_W-HIGH_W){1'b0}}, high_r};
                ADDR_LOCK: rdata_nxt = {{(DATA_W-1){1'b0}}, lock_r};
                ADDR_SAMPLE: rdata_nxt = i_sample;
                default: rdata_nxt = '0;
            endcase
        end
    end

    always_ff @(posedge i_clock) begin
        gain_r <= gain_nxt;
        offset_r <= offset_nxt;
        low_r <= low_nxt;
        high_r <= high_nxt;
        rvalid_r <= rvalid_nxt;
        rdata_r <= rdata_nxt;
        store_r <= store_nxt;
    end

    // ----------------------------------------------------------------
    // Lock
    // ----------------------------------------------------------------
    // Reset reloads the lock from its stored image, so setting the lock
    // always asks for a store; otherwise a reset would undo it.
    always_comb begin
        lock_nxt = lock_r;
        if (!i_rstn) begin
            lock_nxt = i_lock_stored;
        end else if (take && i_cmd_write && (i_cmd_addr == ADDR_LOCK)) begin
            lock_nxt = lock_r | i_cmd_wdata[0];
        end
    end

    always_ff @(posedge i_clock) begin
        lock_r <= lock_nxt;
    end

    // ----------------------------------------------------------------
    // Datapath: multiply, add, limit, clamp
    // ----------------------------------------------------------------
    logic signed [27:0] product;
    logic signed [15:0] scaled;
    logic signed [15:0] offs;
    logic signed [15:0] sum;
    logic signed [15:0] top;
    logic signed [15:0] lim;
    logic signed [15:0] lo;
    logic signed [15:0] hi;
    logic [OUT_W-1:0] out_r, out_nxt;
    logic oe_r, oe_nxt;

    always_comb begin
        // Full-width product; the shift drops the eleven fraction bits
        product = $signed(i_sample) * $signed(gain_r);
        scaled = sat16(32'(product >>> GAIN_FRAC));
        offs = 16'($signed(offset_r)) <<< OFFSET_SHIFT;
        sum = sat16(32'(scaled) + 32'(offs));
        top = reach_top(offs);
        lo = 16'($unsigned(low_r));
        hi = 16'($unsigned(high_r));
        // Low first, then high: crossed limits resolve to the upper one
        lim = min16(max16(min16(sum, top), lo), hi);
        lim = max16(lim, 16'sh0000);
        out_nxt = i_rstn ? lim[OUT_W-1:0] : '0;
        // Communication is ignored once locked, so output stays on
        oe_nxt = i_rstn && !(i_comm_active && !lock_r);
    end

    always_ff @(posedge i_clock) begin
        out_r <= out_nxt;
        oe_r <= oe_nxt;
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign o_out_code = out_r;
    assign o_out_enable = oe_r;
    assign o_rvalid = rvalid_r;
    assign o_rdata = rdata_r;
    assign o_store_req = store_r;
    assign o_locked = lock_r;

endmodule : hall_output_conditioning_lock
`default_nettype wire

/* File: verification/hall_cond_chk_sva.sv */
`timescale 1ns/100ps
`default_nettype none
module hall_cond_chk
    import hall_cond_pkg::*;
(
    input wire logic i_clock, i_rstn, i_comm_active, i_cmd_valid, i_cmd_write, i_cmd_store,
    input wire logic [2:0] i_cmd_addr,
    input wire logic [SAMPLE_W-1:0] i_sample,
    input wire logic [DATA_W-1:0] i_cmd_wdata,
    input wire logic [DATA_W-1:0] o_rdata,
    input wire logic [OUT_W-1:0] o_out_code,
    input wire logic o_rvalid, o_store_req, o_out_enable, o_locked
);
    default clocking @(posedge i_clock); endclocking
    default disable iff (!i_rstn);
    wire logic rd = i_cmd_valid && !i_cmd_write && !o_locked;
    read_answer_a: assert property (rd |=> o_rvalid) else $error("no read answer");
    sample_read_a: assert property (rd && i_cmd_addr == ADDR_SAMPLE |=>
        o_rdata == $past(i_sample)) else $error("sample readout wrong");
    answer_cause_a: assert property (o_rvalid |-> $past(rd)) else $error("stray answer");
    lock_refuse_a: assert property (o_locked && i_cmd_valid |=> !o_rvalid && !o_store_req)
        else $error("command taken while locked");
    lock_sticky_a: assert property (o_locked |=> o_locked) else $error("lock cleared");
    settings_frozen_a: assert property (o_locked && $past(o_locked) && $past(i_rstn) &&
        $stable(i_sample) |=> $stable(o_out_code)) else $error("output moved while locked");
    out_off_a: assert property (i_comm_active && !o_locked |=> !o_out_enable)
        else $error("output driven during exchange");
    out_on_a: assert property (!i_comm_active |=> o_out_enable) else $error("output off");
    store_pulse_a: assert property (i_cmd_valid && i_cmd_write && i_cmd_store &&
        !o_locked && i_cmd_addr <= ADDR_LOCK |=> o_store_req) else $error("no store request");
    lock_store_a: assert property (i_cmd_valid && i_cmd_write && !o_locked &&
        i_cmd_addr == ADDR_LOCK && i_cmd_wdata[0] |=> o_locked && o_store_req)
        else $error("lock not stored");
    cover property (rd && i_cmd_addr == ADDR_SAMPLE);
    cover property (o_locked && i_cmd_valid);
    cover property (o_store_req);
endmodule : hall_cond_chk
bind hall_output_conditioning_lock hall_cond_chk u_hall_cond_chk (.*);
`default_nettype wire

/* File: verification/hall_programmer.sv */
`timescale 1ns/100ps
`default_nettype none
module hall_programmer (
    input wire logic i_clock,
    input wire logic i_rvalid,
    input wire logic [13:0] i_rdata,
    output logic o_comm_active, o_valid, o_write, o_store,
    output logic [2:0] o_addr,
    output logic [13:0] o_wdata
);
    initial {o_comm_active, o_valid, o_write, o_store, o_addr, o_wdata} = '0;
    // One exchange; a released data line shows the inverse of its last value
    task automatic send(input logic w, input logic [2:0] a, input logic [13:0] d,
                        input logic st, output logic ok, output logic [13:0] rd);
        @(posedge i_clock) #1;
        o_comm_active = 1'b1;
        o_valid = 1'b1;
        o_write = w;
        o_addr = a;
        o_wdata = d;
        o_store = st;
        @(posedge i_clock) #1;
        ok = i_rvalid;
        rd = i_rdata;
        o_valid = 1'b0;
        o_wdata = ~o_wdata;
        @(posedge i_clock) #1;
        o_comm_active = 1'b0;
    endtask : send
endmodule : hall_programmer
`default_nettype wire

/* File: verification/tb_hall_output_conditioning_lock.sv */
`timescale 1ns/100ps
`default_nettype none
module tb_hall_output_conditioning_lock
    import hall_cond_pkg::*;
;
    logic i_clock = 1'b0, i_rstn = 1'b0, i_lock_stored = 1'b0;
    logic i_comm_active, i_cmd_valid, i_cmd_write, i_cmd_store, o_rvalid, o_store_req;
    logic o_out_enable, o_locked, ok;
    logic [2:0] i_cmd_addr;
    logic [13:0] i_cmd_wdata, o_rdata, rd, g, o, l, h, s;
    logic [13:0] i_sample = '0;
    logic [10:0] o_out_code, e;
    int err_total = 0;
    int compares = 0;
    int r1, r2, gn, ofs;
    // Calibration targets 1640 codes apart, about 4.0 V at a 5 V supply
    int t1 = 200, t2 = 1840, stores = 0;
    logic [80:0] rows [6] = '{
        {14'h800, 14'h0, 14'h0, 14'h7FF, 14'h400, 11'h400},
        {14'h1000, 14'h0, 14'h0, 14'h7FF, 14'h200, 11'h400},
        {14'h800, 14'h100, 14'h0, 14'h7FF, 14'h0, 11'h200},
        {14'h800, 14'h700, 14'h0, 14'h7FF, 14'hFA0, 11'h600},
        {14'h3800, 14'h0, 14'h200, 14'h7FF, 14'h64, 11'h200},
        {14'h1FFF, 14'h3FF, 14'h0, 14'h400, 14'h1FFF, 11'h400}};
    hall_programmer u_hall_programmer (.i_clock(i_clock), .i_rvalid(o_rvalid),
        .i_rdata(o_rdata), .o_comm_active(i_comm_active), .o_valid(i_cmd_valid),
        .o_write(i_cmd_write), .o_store(i_cmd_store), .o_addr(i_cmd_addr), .o_wdata(i_cmd_wdata));
    hall_output_conditioning_lock u_hall_output_conditioning_lock (.*);
    always #2 i_clock = ~i_clock;
    // Nonvolatile image: a store taken while locked keeps the lock over reset
    always @(posedge i_clock) begin
        if (o_store_req) begin
            stores++;
            i_lock_stored <= i_lock_stored | o_locked;
        end
    end
    task automatic check(input string n, input logic [13:0] exp, got);
        compares++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch %s exp %h got %h", n, exp, got);
        end
    endtask : check
    task automatic put(input logic [2:0] a, input logic [13:0] d);
        u_hall_programmer.send(1'b1, a, d, 1'b0, ok, rd);
    endtask : put
    task automatic get(input logic [2:0] a);
        u_hall_programmer.send(1'b0, a, 14'h0, 1'b0, ok, rd);
    endtask : get
    task automatic summarize();
        $display("compares %0d err_total %0d", compares, err_total);
        if (err_total == 0 && compares > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : summarize
    initial begin
        #10000;
        err_total++;
        summarize();
    end
    initial begin
        repeat (6) @(posedge i_clock);
        #1 i_rstn = 1'b1;
        foreach (rows[i]) begin
            {g, o, l, h, s, e} = rows[i];
            put(ADDR_LOW_LIMIT, l);
            put(ADDR_HIGH_LIMIT, h);
            put(ADDR_GAIN, g);
            put(ADDR_OFFSET, o);
            i_sample = s;
            repeat (2) @(posedge i_clock);
            #1 check("out_code", e, o_out_code);
            check("out_enable", 14'h1, o_out_enable);
        end
        i_sample = 14'h2ABC;
        get(ADDR_SAMPLE);
        check("sample", 14'h2ABC, rd);
        put(ADDR_GAIN, 14'h123);
        u_hall_programmer.send(1'b1, ADDR_GAIN, 14'h456, 1'b1, ok, rd);
        get(ADDR_GAIN);
        check("gain", 14'h456, rd);
        get(3'h7);
        check("unmapped", 14'h0, rd);
        // Two-point calibration: fixed limits, two readouts, computed gain and offset
        put(ADDR_LOW_LIMIT, 14'h0C0);
        put(ADDR_HIGH_LIMIT, 14'h740);
        i_sample = 14'h3C00;
        get(ADDR_SAMPLE);
        r1 = $signed(rd);
        i_sample = 14'h0400;
        fork
            get(ADDR_SAMPLE);
            begin
                repeat (2) @(posedge i_clock);
                #1 check("enable_off", 14'h0, o_out_enable);
            end
        join
        r2 = $signed(rd);
        gn = ((t2 - t1) * 2048) / (r2 - r1);
        ofs = (t1 - ((r1 * gn) >>> 11)) / 2;
        put(ADDR_GAIN, 14'(gn));
        put(ADDR_OFFSET, 14'(ofs));
        repeat (2) @(posedge i_clock);
        #1 check("cal_high", 14'(t2), o_out_code);
        i_sample = 14'h3C00;
        repeat (2) @(posedge i_clock);
        #1 check("cal_low", 14'(t1), o_out_code);
        i_sample = 14'h100;
        u_hall_programmer.send(1'b1, ADDR_LOCK, 14'h1, 1'b1, ok, rd);
        put(ADDR_HIGH_LIMIT, 14'h10);
        fork
            get(ADDR_SAMPLE);
            begin
                repeat (2) @(posedge i_clock);
                #1 check("enable_locked", 14'h1, o_out_enable);
            end
        join
        check("refused", 14'h0, ok);
        check("frozen", 14'h4C9, o_out_code);
        check("stores", 14'h2, 14'(stores));
        i_rstn = 1'b0;
        repeat (2) @(posedge i_clock);
        #1 i_rstn = 1'b1;
        check("locked", 14'h1, o_locked);
        summarize();
    end
endmodule : tb_hall_output_conditioning_lock
`default_nettype wire
